// ---- tlipv_map.svh ----
// Register addresses, reset values, bit positions and vectors of the interrupt controller
`ifndef TLIPV_MAP_SVH
`define TLIPV_MAP_SVH

`define TLIPV_ADDR_ENABLE     8'hA8
`define TLIPV_ADDR_SECONDARY  8'hA9
`define TLIPV_ADDR_LEVEL      8'hB8
`define TLIPV_BITBASE_ENABLE  5'h15
`define TLIPV_BITBASE_LEVEL   5'h17

`define TLIPV_RST_ENABLE      8'h00
`define TLIPV_RST_SECONDARY   8'hA0
`define TLIPV_RST_LEVEL       8'h00
`define TLIPV_SEC_FIXED_MASK  8'h80
`define TLIPV_SEC_FIXED_VAL   8'h80
`define TLIPV_LVL_FIXED_MASK  8'h80
`define TLIPV_LVL_TOP_BIT     3'h7

`define TLIPV_GATE_BIT        7
`define TLIPV_SEC_WAKE_LVL    6
`define TLIPV_SEC_PSM_LVL     5
`define TLIPV_SEC_SER_LVL     4
`define TLIPV_SEC_WAKE_EN     2
`define TLIPV_SEC_PSM_EN      1
`define TLIPV_SEC_SER_EN      0
`define TLIPV_B_ADC           6
`define TLIPV_B_T2            5
`define TLIPV_B_UART          4
`define TLIPV_B_T1            3
`define TLIPV_B_EXT1          2
`define TLIPV_B_T0            1
`define TLIPV_B_EXT0          0
`define TLIPV_WDT_LEVEL       1'b1

`define TLIPV_VEC_EXT0        16'h0003
`define TLIPV_VEC_T0          16'h000B
`define TLIPV_VEC_EXT1        16'h0013
`define TLIPV_VEC_T1          16'h001B
`define TLIPV_VEC_UART        16'h0023
`define TLIPV_VEC_T2          16'h002B
`define TLIPV_VEC_ADC         16'h0033
`define TLIPV_VEC_SER         16'h003B
`define TLIPV_VEC_PSM         16'h0043
`define TLIPV_VEC_WAKE        16'h0053
`define TLIPV_VEC_WDT         16'h005B

`endif

// ---- tlipv_pkg.sv ----
// Types shared by the interrupt controller and its surroundings
`default_nettype none
package tlipv_pkg;

   localparam int NSRC = 11;

   // Sources in polling order, first polled first
   typedef enum logic [3:0] {
      SRC_PSM  = 4'h0,
      SRC_WDT  = 4'h1,
      SRC_EXT0 = 4'h2,
      SRC_ADC  = 4'h3,
      SRC_T0   = 4'h4,
      SRC_EXT1 = 4'h5,
      SRC_T1   = 4'h6,
      SRC_SER  = 4'h7,
      SRC_UART = 4'h8,
      SRC_T2   = 4'h9,
      SRC_WAKE = 4'hA
   } tlipv_src_t;

   // Raw event pulses from the peripherals
   typedef struct packed {
      logic supply_mon_flag;
      logic watchdog_flag;
      logic ext_zero_flag;
      logic primary_conv_ready;
      logic aux_conv_ready;
      logic timer_zero_overflow;
      logic ext_one_flag;
      logic timer_one_overflow;
      logic spi_done_flag;
      logic twowire_done_flag;
      logic uart_rx_flag;
      logic uart_tx_flag;
      logic timer_two_overflow;
      logic timer_two_reload_flag;
      logic wakeup_counter_flag;
   } tlipv_events_t;

   // Request offered to the core
   typedef struct packed {
      logic       valid;
      logic       level;
      tlipv_src_t src;
      logic [15:0] vector;
   } tlipv_req_t;

endpackage : tlipv_pkg
`default_nettype wire

// ---- tlipv_ctrl.sv ----
// Two-level prioritized interrupt controller with fixed vectors
//
// What this block does
// RQ1: Level register bit per source, 1 high.
// RQ2: Bit 7 of both registers ignores writes.
// RQ3: Secondary bits 6..4 set wake, supply, serial levels.
// RQ4: Software keeps secondary bit 3 at zero.
// RQ5: Secondary bits 2..0 enable wake, supply, serial.
// RQ6: Secondary at A9H, resets A0H, byte only.
// RQ7: Source requests only when its enable set.
// RQ8: High request preempts running low routine.
// RQ9: Simultaneous levels: high dispatched first.
// RQ10: Same level blocked while that level active.
// RQ11: Same level resolved by fixed polling order.
// RQ12: Accept pushes PC, loads source vector.
// RQ13: Each source has its fixed vector address.
// RQ14: Shared flags share one request and vector.
// RQ15: Global gate bit blocks all dispatch.
// RQ16: Enable register bits 6..0 map sources.
// RQ17: Level register at B8H, reset zero, bit access.
// RQ18: Watchdog wins tie with external pin 0.
// RQ19: Return instruction releases highest active level; a return in the same cycle as an accept is ignored here.
// RQ20: Pending flag held until dispatched or cleared.
`include "tlipv_map.svh"
`default_nettype none
module tlipv_ctrl (
   // Clock and reset
   input  wire logic                 sys_clk_i,
   input  wire logic                 arst_n_i,
   // Special function register byte access
   input  wire logic [7:0]           sfr_addr_i,
   input  wire logic                 sfr_wr_i,
   input  wire logic [7:0]           sfr_wdata_i,
   output logic      [7:0]           sfr_rdata_o,
   output logic                      sfr_hit_o,
   // Special function register bit access
   input  wire logic [7:0]           bit_addr_i,
   input  wire logic                 bit_wr_i,
   input  wire logic                 bit_wval_i,
   output logic                      bit_rdata_o,
   output logic                      bit_hit_o,
   // Peripheral events and software clears
   input  wire tlipv_pkg::tlipv_events_t events_i,
   input  wire logic [10:0]          flag_clr_i,
   // Core handshake
   input  wire logic                 core_take_i,
   input  wire logic                 core_reti_i,
   output tlipv_pkg::tlipv_req_t     irq_req_o,
   output logic                      pc_push_o,
   output logic      [15:0]          pc_load_vec_o,
   // State seen by the core
   output logic      [10:0]          pending_o,
   output logic      [1:0]           active_lvl_o
);

   logic [7:0]  source_enable_reg;
   logic [7:0]  secondary_control_reg;
   logic [7:0]  level_select_reg;
   logic [10:0] pend;
   logic [10:0] raw_set;
   logic [10:0] src_en;
   logic [10:0] src_lvl;
   logic [1:0]  active;
   logic        global_gate_bit;
   logic        hi_found;
   logic        lo_found;
   logic [3:0]  hi_idx;
   logic [3:0]  lo_idx;
   tlipv_pkg::tlipv_req_t next_req;
   logic        take_now;
   logic        bit_en_hit;
   logic        bit_lvl_hit;

   assign global_gate_bit = source_enable_reg[`TLIPV_GATE_BIT];
   assign bit_en_hit      = (bit_addr_i[7:3] == `TLIPV_BITBASE_ENABLE);
   assign bit_lvl_hit     = (bit_addr_i[7:3] == `TLIPV_BITBASE_LEVEL);

   // Shared flags merge into one request per source
   always_comb begin
      raw_set                = '0;
      raw_set[tlipv_pkg::SRC_PSM]  = events_i.supply_mon_flag;
      raw_set[tlipv_pkg::SRC_WDT]  = events_i.watchdog_flag;
      raw_set[tlipv_pkg::SRC_EXT0] = events_i.ext_zero_flag;
      raw_set[tlipv_pkg::SRC_ADC]  = events_i.primary_conv_ready
                                   | events_i.aux_conv_ready; // RQ14
      raw_set[tlipv_pkg::SRC_T0]   = events_i.timer_zero_overflow;
      raw_set[tlipv_pkg::SRC_EXT1] = events_i.ext_one_flag;
      raw_set[tlipv_pkg::SRC_T1]   = events_i.timer_one_overflow;
      raw_set[tlipv_pkg::SRC_SER]  = events_i.spi_done_flag
                                   | events_i.twowire_done_flag; // RQ14
      raw_set[tlipv_pkg::SRC_UART] = events_i.uart_rx_flag
                                   | events_i.uart_tx_flag; // RQ14
      raw_set[tlipv_pkg::SRC_T2]   = events_i.timer_two_overflow
                                   | events_i.timer_two_reload_flag; // RQ14
      raw_set[tlipv_pkg::SRC_WAKE] = events_i.wakeup_counter_flag;
   end

   // Per-source enable and level, in polling order
   always_comb begin
      src_en  = '0;
      src_lvl = '0;
      src_en[tlipv_pkg::SRC_PSM]   = secondary_control_reg[`TLIPV_SEC_PSM_EN]; // RQ5
      src_lvl[tlipv_pkg::SRC_PSM]  = secondary_control_reg[`TLIPV_SEC_PSM_LVL]; // RQ3
      // Watchdog has no enable bit of its own
      src_en[tlipv_pkg::SRC_WDT]   = 1'b1;
      src_lvl[tlipv_pkg::SRC_WDT]  = `TLIPV_WDT_LEVEL;
      src_en[tlipv_pkg::SRC_EXT0]  = source_enable_reg[`TLIPV_B_EXT0]; // RQ16
      src_lvl[tlipv_pkg::SRC_EXT0] = level_select_reg[`TLIPV_B_EXT0]; // RQ1
      src_en[tlipv_pkg::SRC_ADC]   = source_enable_reg[`TLIPV_B_ADC]; // RQ16
      src_lvl[tlipv_pkg::SRC_ADC]  = level_select_reg[`TLIPV_B_ADC]; // RQ1
      src_en[tlipv_pkg::SRC_T0]    = source_enable_reg[`TLIPV_B_T0]; // RQ16
      src_lvl[tlipv_pkg::SRC_T0]   = level_select_reg[`TLIPV_B_T0]; // RQ1
      src_en[tlipv_pkg::SRC_EXT1]  = source_enable_reg[`TLIPV_B_EXT1]; // RQ16
      src_lvl[tlipv_pkg::SRC_EXT1] = level_select_reg[`TLIPV_B_EXT1]; // RQ1
      src_en[tlipv_pkg::SRC_T1]    = source_enable_reg[`TLIPV_B_T1]; // RQ16
      src_lvl[tlipv_pkg::SRC_T1]   = level_select_reg[`TLIPV_B_T1]; // RQ1
      src_en[tlipv_pkg::SRC_SER]   = secondary_control_reg[`TLIPV_SEC_SER_EN]; // RQ5
      src_lvl[tlipv_pkg::SRC_SER]  = secondary_control_reg[`TLIPV_SEC_SER_LVL]; // RQ3
      src_en[tlipv_pkg::SRC_UART]  = source_enable_reg[`TLIPV_B_UART]; // RQ16
      src_lvl[tlipv_pkg::SRC_UART] = level_select_reg[`TLIPV_B_UART]; // RQ1
      src_en[tlipv_pkg::SRC_T2]    = source_enable_reg[`TLIPV_B_T2]; // RQ16
      src_lvl[tlipv_pkg::SRC_T2]   = level_select_reg[`TLIPV_B_T2]; // RQ1
      src_en[tlipv_pkg::SRC_WAKE]  = secondary_control_reg[`TLIPV_SEC_WAKE_EN]; // RQ5
      src_lvl[tlipv_pkg::SRC_WAKE] = secondary_control_reg[`TLIPV_SEC_WAKE_LVL]; // RQ3
   end

   // Vector lookup per source
   function automatic logic [15:0] tlipv_vector(input logic [3:0] idx);
      logic [15:0] v;
      v = `TLIPV_VEC_PSM;
      case (idx)
         tlipv_pkg::SRC_PSM:  v = `TLIPV_VEC_PSM; // RQ13
         tlipv_pkg::SRC_WDT:  v = `TLIPV_VEC_WDT;
         tlipv_pkg::SRC_EXT0: v = `TLIPV_VEC_EXT0;
         tlipv_pkg::SRC_ADC:  v = `TLIPV_VEC_ADC;
         tlipv_pkg::SRC_T0:   v = `TLIPV_VEC_T0;
         tlipv_pkg::SRC_EXT1: v = `TLIPV_VEC_EXT1;
         tlipv_pkg::SRC_T1:   v = `TLIPV_VEC_T1;
         tlipv_pkg::SRC_SER:  v = `TLIPV_VEC_SER;
         tlipv_pkg::SRC_UART: v = `TLIPV_VEC_UART;
         tlipv_pkg::SRC_T2:   v = `TLIPV_VEC_T2;
         tlipv_pkg::SRC_WAKE: v = `TLIPV_VEC_WAKE;
         default:             v = `TLIPV_VEC_PSM;
      endcase
      return v;
   endfunction : tlipv_vector

   // Polling scan; watchdog sits ahead of pin 0 in the index order
   always_comb begin
      hi_found = 1'b0;
      lo_found = 1'b0;
      hi_idx   = '0;
      lo_idx   = '0;
      for (int i = 0; i < tlipv_pkg::NSRC; i++) begin
         if (pend[i] && src_en[i]) begin // RQ7 RQ20
            if (src_lvl[i] && !hi_found) begin // RQ11 RQ18
               hi_found = 1'b1;
               hi_idx   = 4'(i);
            end else if (!src_lvl[i] && !lo_found) begin // RQ11 RQ18
               lo_found = 1'b1;
               lo_idx   = 4'(i);
            end
         end
      end
   end

   // Level blocking and selection
   always_comb begin
      next_req        = '0;
      next_req.src    = tlipv_pkg::SRC_PSM;
      if (global_gate_bit) begin // RQ15
         if (hi_found && !active[1]) begin // RQ8 RQ9 RQ10
            next_req.valid = 1'b1;
            next_req.level = 1'b1;
            next_req.src   = tlipv_pkg::tlipv_src_t'(hi_idx);
         end else if (lo_found && active == 2'b00) begin // RQ10
            next_req.valid = 1'b1;
            next_req.level = 1'b0;
            next_req.src   = tlipv_pkg::tlipv_src_t'(lo_idx);
         end
      end
      next_req.vector = tlipv_vector(next_req.src); // RQ13
   end

   // Stale offer is never taken twice: the registered request drops after a take
   assign take_now = core_take_i && irq_req_o.valid;

   // Request register toward the core
   always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         irq_req_o     <= '0;
      end else if (take_now) begin
         irq_req_o     <= '0;
      end else begin
         irq_req_o     <= next_req;
      end
   end

   // Push and vector load strobe on acceptance
   always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         pc_push_o     <= 1'b0;
         pc_load_vec_o <= '0;
      end else begin
         pc_push_o     <= take_now; // RQ12
         if (take_now) begin
            pc_load_vec_o <= irq_req_o.vector; // RQ12
         end
      end
   end

   // Pending flags; a new event beats a clear in the same cycle
   always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         pend <= '0;
      end else begin
         for (int i = 0; i < tlipv_pkg::NSRC; i++) begin
            if (raw_set[i]) begin
               pend[i] <= 1'b1; // RQ20
            end else if (flag_clr_i[i] ||
                         (take_now && irq_req_o.src == 4'(i))) begin
               pend[i] <= 1'b0; // RQ20
            end
         end
      end
   end

   // Active level tracking
   always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         active <= 2'b00;
      end else begin
         if (take_now) begin
            active[irq_req_o.level] <= 1'b1; // RQ8 RQ10
         end
         if (core_reti_i && !take_now) begin
            if (active[1]) begin
               active[1] <= 1'b0; // RQ19
            end else begin
               active[0] <= 1'b0; // RQ19
            end
         end
      end
   end

   // Byte writes to the three registers, bit writes to enable and level
   always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         source_enable_reg     <= `TLIPV_RST_ENABLE;
         secondary_control_reg <= `TLIPV_RST_SECONDARY; // RQ6
         level_select_reg      <= `TLIPV_RST_LEVEL; // RQ17
      end else begin
         if (sfr_wr_i) begin
            case (sfr_addr_i)
               `TLIPV_ADDR_ENABLE: begin
                  source_enable_reg <= sfr_wdata_i;
               end
               `TLIPV_ADDR_SECONDARY: begin
                  // Upper bit stays at its reset value
                  secondary_control_reg <= (sfr_wdata_i & ~`TLIPV_SEC_FIXED_MASK)
                                         | `TLIPV_SEC_FIXED_VAL; // RQ2 RQ6
               end
               `TLIPV_ADDR_LEVEL: begin
                  level_select_reg <= sfr_wdata_i & ~`TLIPV_LVL_FIXED_MASK; // RQ2
               end
               default: begin
               end
            endcase
         end
         // Secondary register has no bit address
         if (bit_wr_i && bit_en_hit) begin
            source_enable_reg[bit_addr_i[2:0]] <= bit_wval_i;
         end
         if (bit_wr_i && bit_lvl_hit && bit_addr_i[2:0] != `TLIPV_LVL_TOP_BIT) begin
            level_select_reg[bit_addr_i[2:0]] <= bit_wval_i; // RQ2 RQ17
         end
      end
   end

   // Read data, one cycle after the address
   always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         sfr_rdata_o <= '0;
         sfr_hit_o   <= 1'b0;
         bit_rdata_o <= 1'b0;
         bit_hit_o   <= 1'b0;
      end else begin
         case (sfr_addr_i)
            `TLIPV_ADDR_ENABLE: begin
               sfr_rdata_o <= source_enable_reg;
               sfr_hit_o   <= 1'b1;
            end
            `TLIPV_ADDR_SECONDARY: begin
               sfr_rdata_o <= secondary_control_reg;
               sfr_hit_o   <= 1'b1;
            end
            `TLIPV_ADDR_LEVEL: begin
               sfr_rdata_o <= level_select_reg;
               sfr_hit_o   <= 1'b1;
            end
            default: begin
               sfr_rdata_o <= '0;
               sfr_hit_o   <= 1'b0;
            end
         endcase
         if (bit_en_hit) begin
            bit_rdata_o <= source_enable_reg[bit_addr_i[2:0]];
         end else if (bit_lvl_hit) begin
            bit_rdata_o <= level_select_reg[bit_addr_i[2:0]];
         end else begin
            bit_rdata_o <= 1'b0;
         end
         bit_hit_o <= bit_en_hit || bit_lvl_hit;
      end
   end

   // Status mirrors
   always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         pending_o    <= '0;
         active_lvl_o <= 2'b00;
      end else begin
         pending_o    <= pend;
         active_lvl_o <= active;
      end
   end

endmodule : tlipv_ctrl
`default_nettype wire

// ---- tlipv_chk.sv ----
// Port assertions for the interrupt controller
`default_nettype none
module tlipv_chk (
   // Clock and reset
   input wire logic                     sys_clk_i,
   input wire logic                     arst_n_i,
   // Register access
   input wire logic [7:0]               sfr_addr_i,
   input wire logic                     sfr_wr_i,
   input wire logic [7:0]               sfr_wdata_i,
   input wire logic [7:0]               sfr_rdata_o,
   input wire logic                     sfr_hit_o,
   input wire logic [7:0]               bit_addr_i,
   input wire logic                     bit_wr_i,
   input wire logic                     bit_wval_i,
   input wire logic                     bit_rdata_o,
   input wire logic                     bit_hit_o,
   // Events and core
   input wire tlipv_pkg::tlipv_events_t events_i,
   input wire logic [10:0]              flag_clr_i,
   input wire logic                     core_take_i,
   input wire logic                     core_reti_i,
   input wire tlipv_pkg::tlipv_req_t    irq_req_o,
   input wire logic                     pc_push_o,
   input wire logic [15:0]              pc_load_vec_o,
   input wire logic [10:0]              pending_o,
   input wire logic [1:0]               active_lvl_o
);
   timeunit 1ns;
   timeprecision 100ps;
   localparam logic [15:0] VEC [11] = '{16'h0043, 16'h005B, 16'h0003, 16'h0033, 16'h000B,
      16'h0013, 16'h001B, 16'h003B, 16'h0023, 16'h002B, 16'h0053};
   logic gate;
   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (!arst_n_i);
   // Shadow of the global gate; bit write wins over byte write
   always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         gate <= 1'b0;
      end else if (bit_wr_i && bit_addr_i == 8'hAF) begin
         gate <= bit_wval_i;
      end else if (sfr_wr_i && sfr_addr_i == 8'hA8) begin
         gate <= sfr_wdata_i[7];
      end
   end
   sequence s_take;
      core_take_i && irq_req_o.valid;
   endsequence
   sequence s_ret;
      core_reti_i && !core_take_i ##1 1'b1;
   endsequence
   a_vec_fixed: assert property (
      irq_req_o.valid |-> irq_req_o.src <= 4'hA && irq_req_o.vector == VEC[irq_req_o.src])
      else $error("offered vector differs from source table");
   a_push_vector: assert property (
      s_take |=> pc_push_o && pc_load_vec_o == $past(irq_req_o.vector))
      else $error("accepted request gave no push with its vector");
   a_push_pulse: assert property (pc_push_o |-> !irq_req_o.valid ##1 !pc_push_o)
      else $error("push pulse too long or offer kept");
   a_gate_blocks: assert property (!gate [*2] |-> !irq_req_o.valid)
      else $error("offer while gate clear");
   a_high_blocked: assert property (
      active_lvl_o[1] |-> !(irq_req_o.valid && irq_req_o.level))
      else $error("high offer while high active");
   a_low_blocked: assert property (
      active_lvl_o != 2'b00 |-> !(irq_req_o.valid && !irq_req_o.level))
      else $error("low offer while a level active");
   a_offer_pending: assert property (
      irq_req_o.valid |-> irq_req_o.src <= 4'hA && pending_o[irq_req_o.src])
      else $error("offer without pending flag");
   a_sec_top: assert property (sfr_addr_i == 8'hA9 |=> sfr_hit_o && sfr_rdata_o[7])
      else $error("secondary top bit not one");
   a_level_top: assert property (sfr_addr_i == 8'hB8 |=> sfr_hit_o && !sfr_rdata_o[7])
      else $error("level top bit not zero");
   a_ret_release: assert property (
      s_ret |=> active_lvl_o == ($past(active_lvl_o[1]) ? {1'b0, $past(active_lvl_o[0])} : 2'b00))
      else $error("return released wrong level");
   c_nested: cover property (active_lvl_o == 2'b01 && irq_req_o.valid && irq_req_o.level);
endmodule : tlipv_chk
bind tlipv_ctrl tlipv_chk u_chk (.*);
`default_nettype wire

// ---- tlipv_core_mdl.sv ----
// Core-side model: takes offers after a lag, pushes, returns on command
`default_nettype none
module tlipv_core_mdl (
   // Clock and reset
   input  wire logic                  sys_clk_i,
   input  wire logic                  arst_n_i,
   // Controller side
   input  wire tlipv_pkg::tlipv_req_t irq_req_i,
   input  wire logic                  pc_push_i,
   input  wire logic [15:0]           pc_vec_i,
   output logic                       take_o,
   output logic                       reti_o
);
   timeunit 1ns;
   timeprecision 100ps;
   int          lag = 0;
   bit          on = 1'b0;
   int          cnt = 0;
   int          depth = 0;
   logic [15:0] pc = 16'h0000;
   initial begin
      take_o = 1'b0;
      reti_o = 1'b0;
   end
   // Takes only a standing offer; off while the bench reconfigures
   always @(posedge sys_clk_i) begin
      #1;
      if (take_o || !on || !arst_n_i || irq_req_i.valid !== 1'b1) begin
         take_o = 1'b0;
         cnt = 0;
      end else if (cnt >= lag) begin
         take_o = 1'b1;
      end else begin
         cnt++;
      end
      if (pc_push_i === 1'b1) begin
         depth++;
         pc = pc_vec_i;
      end
   end
   task automatic do_reti();
      @(posedge sys_clk_i);
      #1;
      reti_o = 1'b1;
      @(posedge sys_clk_i);
      #1;
      reti_o = 1'b0;
      depth--;
   endtask : do_reti
endmodule : tlipv_core_mdl
`default_nettype wire

// ---- tb.sv ----
// Self-checking bench for the interrupt controller
`default_nettype none
module tb;
   timeunit 1ns;
   timeprecision 100ps;
   localparam int evp [11] = '{14, 13, 12, 11, 9, 8, 7, 6, 4, 2, 0};
   localparam int enp [11] = '{9, 0, 0, 6, 1, 2, 3, 8, 4, 5, 10};
   localparam int lvp [11] = '{13, 0, 0, 6, 1, 2, 3, 12, 4, 5, 14};
   localparam logic [15:0] vtab [11] = '{16'h0043, 16'h005B, 16'h0003, 16'h0033, 16'h000B,
      16'h0013, 16'h001B, 16'h003B, 16'h0023, 16'h002B, 16'h0053};
   logic clk = 0, rst_n = 0, wr_s = 0, bwr = 0, bval = 0, hit, brd, bhit, take, reti, push;
   logic [7:0] addr = 0, wd = 0, baddr = 0, rdata, m_en = 0, m_sec = 8'hA0, m_lvl = 0;
   logic [14:0] ev = 0;
   logic [10:0] clr = 0, pend, m_pend = 0;
   logic [15:0] vec;
   logic [1:0] act;
   logic m_hi = 0, m_lo = 0;
   tlipv_pkg::tlipv_req_t req;
   int fail_count = 0, tests_run = 0;
   tlipv_ctrl uut (.sys_clk_i(clk), .arst_n_i(rst_n), .sfr_addr_i(addr), .sfr_wr_i(wr_s),
      .sfr_wdata_i(wd), .sfr_rdata_o(rdata), .sfr_hit_o(hit), .bit_addr_i(baddr),
      .bit_wr_i(bwr), .bit_wval_i(bval), .bit_rdata_o(brd), .bit_hit_o(bhit),
      .events_i(tlipv_pkg::tlipv_events_t'(ev)), .flag_clr_i(clr), .core_take_i(take),
      .core_reti_i(reti), .irq_req_o(req), .pc_push_o(push), .pc_load_vec_o(vec),
      .pending_o(pend), .active_lvl_o(act));
   tlipv_core_mdl core (.sys_clk_i(clk), .arst_n_i(rst_n), .irq_req_i(req), .pc_push_i(push),
      .pc_vec_i(vec), .take_o(take), .reti_o(reti));
   initial begin
      forever #5 clk = ~clk;
   end
   task automatic tally_and_finish();
      $display("comparisons %0d mismatches %0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : tally_and_finish
   task automatic chk_reg(input logic [8:0] got, input logic [8:0] exp);
      tests_run++;
      if (got !== exp) begin
         fail_count++;
         $display("[FAIL] t=%0t reg got=%h exp=%h", $time, got, exp);
      end
   endtask : chk_reg
   task automatic chk_irq(input logic [20:0] got, input logic [20:0] exp);
      tests_run++;
      if (got !== exp) begin
         fail_count++;
         $display("[FAIL] t=%0t irq got=%h exp=%h", $time, got, exp);
      end
   endtask : chk_irq
   task automatic tick(inout int n);
      @(posedge clk);
      #1;
      n++;
      if (n > 40) begin
         fail_count++;
         $display("[FAIL] t=%0t wait got=%h exp=%h", $time, n, 40);
         tally_and_finish();
      end
   endtask : tick
   function automatic int lv(int s);
      logic [15:0] l;
      l = {m_sec, m_lvl};
      return (s == 1) ? 1 : int'(l[lvp[s]]);
   endfunction : lv
   // Highest level first, then polling order; watchdog always enabled
   function automatic int predict();
      logic [15:0] e;
      e = {m_sec, m_en};
      for (int h = 1; h >= 0; h--)
         if (m_en[7] && !m_hi && !(h == 0 && m_lo))
            for (int s = 0; s < 11; s++)
               if (m_pend[s] && (s == 1 || e[enp[s]]) && lv(s) == h) return s;
      return -1;
   endfunction : predict
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      #1;
      {addr, wr_s, wd} = {a, 1'b1, d};
      @(posedge clk);
      #1;
      wr_s = 1'b0;
      if (a == 8'hA8) m_en = d;
      if (a == 8'hA9) m_sec = d | 8'h80;
      if (a == 8'hB8) m_lvl = d & 8'h7F;
   endtask : wr
   task automatic rd(input logic [7:0] a);
      @(posedge clk);
      #1;
      addr = a;
      @(posedge clk);
      #1;
      chk_reg({hit, rdata}, a == 8'hA8 ? {1'b1, m_en} : a == 8'hA9 ? {1'b1, m_sec} :
         a == 8'hB8 ? {1'b1, m_lvl} : 9'h000);
   endtask : rd
   task automatic bw(input logic [7:0] a, input logic v);
      @(posedge clk);
      #1;
      {baddr, bwr, bval} = {a, 1'b1, v};
      @(posedge clk);
      #1;
      bwr = 1'b0;
      if (a < 8'hB0) m_en[a[2:0]] = v;
      else if (a != 8'hBF) m_lvl[a[2:0]] = v;
      @(posedge clk);
      #1;
      chk_reg({bhit, 7'h00, brd}, {1'b1, 7'h00, a < 8'hB0 ? m_en[a[2:0]] : m_lvl[a[2:0]]});
   endtask : bw
   task automatic fire(input logic [10:0] m);
      @(posedge clk);
      #1;
      for (int s = 0; s < 11; s++)
         if (m[s]) ev[evp[s] - ((s inside {3, 7, 8, 9}) ? int'($urandom % 2) : 0)] = 1'b1;
      @(posedge clk);
      #1;
      ev = '0;
      m_pend |= m;
   endtask : fire
   task automatic serve();
      int e;
      int n;
      n = 0;
      tick(n);
      core.on = 1'b1;
      e = predict();
      if (e < 0) begin
         repeat (4) begin
            tick(n);
            chk_irq({20'h0, req.valid}, 21'h0);
         end
      end else begin
         while (req.valid !== 1'b1) tick(n);
         chk_irq({req.level, req.src, req.vector}, {1'(lv(e)), 4'(e), vtab[e]});
         while (push !== 1'b1) tick(n);
         chk_irq({5'h0, vec}, {5'h0, vtab[e]});
         m_pend[e] = 1'b0;
         if (lv(e) == 1) m_hi = 1'b1;
         else m_lo = 1'b1;
      end
      core.on = 1'b0;
   endtask : serve
   task automatic ret();
      core.do_reti();
      if (m_hi) m_hi = 1'b0;
      else m_lo = 1'b0;
      repeat (2) @(posedge clk);
      #1;
      chk_irq({6'h0, 2'(core.depth), act, pend},
         {6'h0, {1'b0, m_hi} + {1'b0, m_lo}, m_hi, m_lo, m_pend});
   endtask : ret
   initial begin
      void'($urandom(64110));
      repeat (5) @(posedge clk);
      #1 rst_n = 1'b1;
      rd(8'hA8);
      rd(8'hA9);
      rd(8'hB8);
      rd(8'h55);
      wr(8'hA9, 8'($urandom) & 8'h77);
      rd(8'hA9);
      wr(8'hB8, 8'hFF);
      rd(8'hB8);
      for (int k = 0; k < 8; k++) begin
         bw(8'hB8 + 8'(k), 1'($urandom));
         bw(8'hA8 + 8'(k), 1'($urandom));
      end
      wr(8'hA8, 8'hFF);
      wr(8'hA9, 8'h07);
      wr(8'hB8, 8'h00);
      for (int s = 0; s < 11; s++) begin
         core.lag = $urandom % 4;
         fire(11'h001 << s);
         serve();
         ret();
      end
      wr(8'hB8, 8'h08);
      fire(11'h044);
      serve();
      ret();
      serve();
      ret();
      fire(11'h010);
      serve();
      fire(11'h140);
      serve();
      serve();
      ret();
      serve();
      ret();
      serve();
      ret();
      wr(8'hA8, 8'h7F);
      fire(11'h004);
      serve();
      wr(8'hA8, 8'h80);
      serve();
      wr(8'hA8, 8'h81);
      serve();
      ret();
      fire(11'h010);
      @(posedge clk);
      #1 clr = 11'h010;
      @(posedge clk);
      #1 clr = 11'h000;
      m_pend[4] = 1'b0;
      wr(8'hA8, 8'h82);
      serve();
      for (int r = 0; r < 8; r++) begin
         wr(8'hA8, 8'($urandom) | 8'h80);
         wr(8'hA9, 8'($urandom) & 8'h77);
         wr(8'hB8, 8'($urandom));
         fire(11'($urandom));
         while (predict() >= 0) begin
            serve();
            ret();
         end
         serve();
      end
      tally_and_finish();
   end
endmodule : tb
`default_nettype wire
